//--- design/cir_top.sv
// Cascaded interrupt controller pair with level-two redirect
// Behaviour
// - PCI request lines are sampled as levels and ISA request lines as rising edges.
// - An end_of_service_command clears the in-service bit of the serviced level.
// - The end_of_service_command is honoured whether the request line is high or low.
// - A level request still high at end_of_service_command is taken as a new request.
// - legacy_cascade_level_request is routed to level nine of the second controller.
// - Level nine is delivered as vector 71h; level two's routine sits at vector 0ah.
// - An interrupt-in-progress latch is readable at an I/O bit and clears on that read.
// - Writes to the edge-sharing reset ports leave interrupt operation untouched.
`timescale 1ns/10ps
`default_nettype none
`include "cir_params.svh"
module cir_top #(
  parameter int LEVELS = `CIR_LEVELS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2*LEVELS-1:0] irq_pins,
  input wire logic [2*LEVELS-1:0] level_mode,
  input wire logic legacy_cascade_level_request,
  input wire cir_pkg::cir_io_t io,
  input wire logic int_ack,
  input wire logic eoi_master,
  input wire logic eoi_slave,
  output logic int_req,
  output logic [7:0] vector_q,
  output logic [7:0] io_rdata_q,
  output logic share_reset_seen_q
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Every pin passes four flops; a new level counts only once the
  // second and third flop agree, so one unsettled sample never counts
  localparam int NPINS = 2 * LEVELS + 1;
  wire [NPINS-1:0] pin_raw = {legacy_cascade_level_request, irq_pins};
  logic [NPINS-1:0] pin_clean;
  genvar g;
  for (g = 0; g < NPINS; g++) begin : g_sync
    logic f1_q;
    logic f2_q;
    logic f3_q;
    logic hold_q;
    wire agree = f2_q == f3_q;
    wire hold_d = agree ? f3_q : hold_q;
    always_ff @(posedge clk) begin
      if (reset) begin
        f1_q <= 1'b0;
        f2_q <= 1'b0;
        f3_q <= 1'b0;
        hold_q <= 1'b0;
      end else begin
        f1_q <= pin_raw[g];
        f2_q <= f1_q;
        f3_q <= f2_q;
        hold_q <= hold_d;
      end
    end
    assign pin_clean[g] = hold_q;
  end : g_sync
  wire [2*LEVELS-1:0] pin_lvl = pin_clean[2*LEVELS-1:0];
  wire leg_lvl = pin_clean[2*LEVELS];

  // ----------------------------------------
  // Line assembly
  // ----------------------------------------
  logic [2*LEVELS-1:0] line_prev_q;
  logic [2*LEVELS-1:0] irr_q;
  logic [2*LEVELS-1:0] isr_q;
  logic latch_q;
  // The legacy level-two line lands on level nine of the second controller
  localparam int REDIR_BIT = LEVELS + `CIR_REDIRECT_LEVEL;
  wire [2*LEVELS-1:0] redir_line = (2*LEVELS)'(leg_lvl) << REDIR_BIT;
  wire [2*LEVELS-1:0] line = pin_lvl | redir_line;
  wire [2*LEVELS-1:0] edge_hit = line & ~line_prev_q;
  // Level lines re-request whenever still high, so a line held at
  // end of service fires again
  wire [2*LEVELS-1:0] level_new = level_mode & line;
  wire [2*LEVELS-1:0] edge_new = ~level_mode & edge_hit;
  wire [2*LEVELS-1:0] new_req = level_new | edge_new;
  // A level request that goes away before acknowledge is withdrawn
  wire [2*LEVELS-1:0] level_gone = level_mode & ~line;

  // ----------------------------------------
  // Priority decode
  // ----------------------------------------
  // Lowest-numbered pending level wins; code 8 means none
  function automatic logic [3:0] pick(input logic [LEVELS-1:0] req);
    pick = 4'h8;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (req[i]) pick = 4'(i);
    end
  endfunction : pick
  function automatic logic [LEVELS-1:0] onehot(input logic [3:0] sel);
    onehot = sel[3] ? '0 : ((LEVELS)'(1) << sel[2:0]);
  endfunction : onehot
  wire [LEVELS-1:0] s_irr = irr_q[2*LEVELS-1:LEVELS];
  wire [LEVELS-1:0] s_isr = isr_q[2*LEVELS-1:LEVELS];
  wire [LEVELS-1:0] m_irr = irr_q[LEVELS-1:0];
  wire [LEVELS-1:0] m_isr = isr_q[LEVELS-1:0];

  // ----------------------------------------
  // Second controller
  // ----------------------------------------
  wire [LEVELS-1:0] s_pend = s_irr & ~s_isr;
  wire [3:0] s_sel = pick(s_pend);
  wire slave_out = ~s_sel[3];

  // ----------------------------------------
  // Master controller and cascade
  // ----------------------------------------
  // The second controller's output stands on the master's cascade level
  wire [LEVELS-1:0] cascade_bit = (LEVELS)'(slave_out) << `CIR_CASCADE_LEVEL;
  wire [LEVELS-1:0] m_req = m_irr | cascade_bit;
  wire [LEVELS-1:0] m_pend = m_req & ~m_isr;
  wire [3:0] m_sel = pick(m_pend);
  wire m_any = ~m_sel[3];
  wire m_on_cascade = m_sel[2:0] == `CIR_CASCADE_LEVEL;
  // Acknowledge with nothing pending is ignored
  wire ack_any = int_ack && m_any;
  wire ack_slave = ack_any && m_on_cascade;
  wire ack_master = ack_any && !m_on_cascade;

  // ----------------------------------------
  // In-service and request update
  // ----------------------------------------
  wire [LEVELS-1:0] m_set = ack_any ? onehot(m_sel) : '0;
  wire [LEVELS-1:0] s_set = ack_slave ? onehot(s_sel) : '0;
  // The cascade level has no request bit of its own to consume
  wire [LEVELS-1:0] m_take = ack_master ? onehot(m_sel) : '0;
  // End of service is non-specific and ignores the request lines
  wire [LEVELS-1:0] m_clr = eoi_master ? onehot(pick(m_isr)) : '0;
  wire [LEVELS-1:0] s_clr = eoi_slave ? onehot(pick(s_isr)) : '0;
  wire [2*LEVELS-1:0] taken = {s_set, m_take};
  wire [2*LEVELS-1:0] set_isr = {s_set, m_set};
  wire [2*LEVELS-1:0] clr_isr = {s_clr, m_clr};
  wire [2*LEVELS-1:0] irr_keep = irr_q & ~taken & ~level_gone;
  wire [2*LEVELS-1:0] irr_d = irr_keep | new_req;
  wire [2*LEVELS-1:0] isr_d = (isr_q & ~clr_isr) | set_isr;

  // ----------------------------------------
  // I/O port decode
  // ----------------------------------------
  wire [11:0] io_page = io.addr[15:4];
  wire page_share_a = io_page == `CIR_SHARE_PORT_A;
  wire page_share_b = io_page == `CIR_SHARE_PORT_B;
  wire share_page = page_share_a || page_share_b;
  // Sharing reset writes are only noted; they reach no request state
  wire share_wr = io.valid && io.write && share_page;
  wire latch_rd = io.valid && !io.write && io_page == `CIR_LATCH_PORT;

  // ----------------------------------------
  // Vector and latch next values
  // ----------------------------------------
  wire [7:0] s_vec = `CIR_SLAVE_BASE + 8'(s_sel[2:0]);
  wire [7:0] m_vec = `CIR_MASTER_BASE + 8'(m_sel[2:0]);
  wire [7:0] vec_d = ack_slave ? s_vec : m_vec;
  // Set beats the clearing read
  wire latch_d = ack_any | (latch_q & ~latch_rd);
  wire [7:0] rdata_d = latch_rd ? {7'h00, latch_q} : io_rdata_q;

  // ----------------------------------------
  // Request state registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      line_prev_q <= '0;
      irr_q <= '0;
      isr_q <= '0;
    end else begin
      line_prev_q <= line;
      irr_q <= irr_d;
      isr_q <= isr_d;
    end
  end

  // ----------------------------------------
  // Vector register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      vector_q <= 8'h00;
    end else if (ack_any) begin
      vector_q <= vec_d;
    end
  end

  // ----------------------------------------
  // I/O side registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q <= 1'b0;
      io_rdata_q <= 8'h00;
      share_reset_seen_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      io_rdata_q <= rdata_d;
      share_reset_seen_q <= share_wr;
    end
  end

  // ----------------------------------------
  // Processor request
  // ----------------------------------------
  assign int_req = m_any;
endmodule : cir_top
`default_nettype wire

//--- pkg/cir_params.svh
// Constants of the cascaded interrupt redirect block
`ifndef CIR_PARAMS_SVH
`define CIR_PARAMS_SVH
`define CIR_LEVELS 8
`define CIR_CASCADE_LEVEL 3'h2
`define CIR_REDIRECT_LEVEL 3'h1
`define CIR_MASTER_BASE 8'h08
`define CIR_SLAVE_BASE 8'h70
`define CIR_SHARE_PORT_A 12'h02f
`define CIR_SHARE_PORT_B 12'h06f
`define CIR_LATCH_PORT 12'h0e0
`endif

//--- pkg/cir_pkg.sv
// Types of the cascaded interrupt redirect block
package cir_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cir_io_t;
  typedef enum logic {CIR_MASTER, CIR_SLAVE} cir_ctrl_t;
endpackage : cir_pkg

//--- test/cir_checker.sv
// Port checker for the interrupt pair
`timescale 1ns/10ps
`default_nettype none
module cir_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic legacy_cascade_level_request,
  input wire cir_pkg::cir_io_t io,
  input wire logic int_ack,
  input wire logic int_req,
  input wire logic [7:0] vector_q,
  input wire logic [7:0] io_rdata_q,
  input wire logic share_reset_seen_q
);
  wire [11:0] pg = io.addr[15:4];
  wire shr = io.valid && io.write && (pg == 12'h02f || pg == 12'h06f);
  wire lrd = io.valid && !io.write && pg == 12'h0e0;
  wire ack = int_ack && int_req;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_vector_range: assert property (ack |=> vector_q[7:3] inside {5'h01, 5'h0e})
    else $error("vector out of range");
  a_vector_hold: assert property (!ack |=> $stable(vector_q))
    else $error("vector moved");
  a_share_seen: assert property (shr |=> share_reset_seen_q)
    else $error("share write missed");
  a_share_quiet: assert property (!shr |=> !share_reset_seen_q)
    else $error("share flag stray");
  a_share_novec: assert property (shr && !int_ack |=> $stable(vector_q))
    else $error("share write disturbed");
  a_redirect_req: assert property ($rose(legacy_cascade_level_request) |-> ##[1:8] int_req)
    else $error("redirect late");
  a_latch_bits: assert property (lrd |=> io_rdata_q[7:1] == 7'h00)
    else $error("latch bits");
  a_latch_hold: assert property (!lrd |=> $stable(io_rdata_q))
    else $error("latch moved");
  c_ack: cover property (ack);
  c_share: cover property (share_reset_seen_q);
  c_latch: cover property (io_rdata_q[0]);
endmodule : cir_checker
bind cir_top cir_checker chk (.clk, .reset, .legacy_cascade_level_request, .io, .int_ack,
  .int_req, .vector_q, .io_rdata_q, .share_reset_seen_q);
`default_nettype wire

//--- test/cir_dev_model.sv
// Level-type interrupting device
`timescale 1ns/10ps
`default_nettype none
module cir_dev_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic raise,
  input wire logic clear,
  output logic irq
);
  always_ff @(posedge clk) begin
    if (reset || clear) irq <= 1'b0;
    else if (raise) irq <= 1'b1;
  end
endmodule : cir_dev_model
`default_nettype wire

//--- test/cir_top_tb_top.sv
// Self-checking bench for the interrupt pair
`timescale 1ns/10ps
`default_nettype none
module cir_top_tb_top;
  logic clk = 0, reset = 1, lcl = 0, ack = 0, eom = 0, eos = 0, isa3 = 0, raise = 0, clr = 0;
  logic int_req, share, dev_irq;
  logic [7:0] vec, rd;
  logic [31:0] lfsr = 32'h8397c4a2;
  cir_pkg::cir_io_t io = '0;
  int mismatches = 0, n_compared = 0;
  byte unsigned q[$];
  always #20 clk = ~clk;
  cir_dev_model dev (.clk, .reset, .raise, .clear(clr), .irq(dev_irq));
  cir_top uut (.clk, .reset, .irq_pins({10'h000, dev_irq, 1'b0, isa3, 3'h0}),
    .level_mode(16'h0020), .legacy_cascade_level_request(lcl), .io, .int_ack(ack),
    .eoi_master(eom), .eoi_slave(eos), .int_req, .vector_q(vec), .io_rdata_q(rd),
    .share_reset_seen_q(share));
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task chk(string n, logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task take(int lvl);
    int i;
    q.push_back(lvl < 8 ? 8'h08 + lvl : 8'h70 + lvl - 8);
    for (i = 0; i < 20 && int_req !== 1'b1; i++) cyc(1);
    if (i == 20) begin
      mismatches++;
      report_and_stop;
    end
    ack = 1;
    cyc(1);
    ack = 0;
    chk("vector", vec, q.pop_front());
  endtask : take
  task end_of_service_command(logic m);
    eom = m;
    eos = !m;
    cyc(1);
    eom = 0;
    eos = 0;
  endtask : end_of_service_command
  task iow(logic w, logic [15:0] a);
    io = '{1'b1, w, a, lfsr[7:0]};
    lfsr = lfsr_next(lfsr);
    cyc(1);
    io = '0;
  endtask : iow
  initial begin
    cyc(8);
    reset = 0;
    isa3 = 1;
    take(3);
    end_of_service_command(1);
    cyc(10);
    chk("edge_rearm", int_req, 0);
    $display("edge test done");
    raise = 1;
    cyc(1);
    raise = 0;
    take(5);
    end_of_service_command(1);
    take(5);
    clr = 1;
    cyc(2);
    clr = 0;
    end_of_service_command(1);
    cyc(10);
    chk("level_idle", int_req, 0);
    $display("level test done");
    lcl = 1;
    take(9);
    iow(0, {12'h0e0, lfsr[3:0]});
    chk("latch", rd[0], 1);
    iow(0, 16'h0e00);
    chk("latch_clr", rd[0], 0);
    end_of_service_command(0);
    lcl = 0;
    end_of_service_command(1);
    iow(1, {12'h02f, lfsr[3:0]});
    chk("share", share, 1);
    chk("share_quiet", int_req, 0);
    $display("redirect test done");
    report_and_stop;
  end
endmodule : cir_top_tb_top
`default_nettype wire
